/* File: fsps_sequencer.sv */
`timescale 1ns/1ps
`include "fsps_regs.svh"

module fsps_sequencer #(
   parameter int WORD_BITS = 6,             // word index width
   parameter int PAGE_BITS = 15 - WORD_BITS, // page index width
   parameter int LIVE_PAGES = 448           // pages readable while write
)(
   input  wire logic                 mclk,
   input  wire logic                 arst_n,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire logic                 eeprom_write_busy,
   input  wire logic                 eeprom_write_start,
   output fsps_pkg::fsps_op_t        fl_op,
   output logic                      fl_start,
   output logic [PAGE_BITS-1:0]      fl_page,
   output logic [3:0]                fl_lock_bits,
   input  wire logic                 fl_done,
   input  wire logic [WORD_BITS-1:0] fl_buf_idx,
   output logic [15:0]               fl_buf_data,
   output logic [15:0]               load_addr,
   input  wire logic [7:0]           load_rdata,
   output logic                      cpu_halt,
   output logic                      section_block,
   output logic                      spm_irq
);

   localparam int NWORDS = 1 << WORD_BITS;         // words in a page
   localparam logic [PAGE_BITS-1:0] LIVE_LIM = PAGE_BITS'(LIVE_PAGES);

   // bus pipeline
   logic                   wr_pend_q;    // write data phase pending
   logic [7:0]             wr_ofs_q;     // offset of pending write
   logic                   hreadyout_q;  // always ready
   logic                   hresp_q;      // always okay
   logic [31:0]            hrdata_q;     // read data for data phase
   logic [31:0]            rd_val;       // read mux
   logic                   acc;          // address phase taken

   // software visible state
   logic [15:0]            ptr_q;        // address pointer
   logic [15:0]            data_q;       // data pair, high:low
   logic                   pgm_en_q;     // program enable bit
   logic                   ers_q;        // page erase command bit
   logic                   wrt_q;        // page write command bit
   logic                   lock_q;       // lock set command bit
   logic                   bclr_q;       // busy clear command bit
   logic                   ien_q;        // interrupt enable
   logic                   busy_q;       // section busy flag
   logic [2:0]             cnt_q;        // arm window countdown

   // sequencer state
   fsps_pkg::fsps_state_t  state_q;
   fsps_pkg::fsps_op_t     fl_op_q;
   logic                   fl_start_q;
   logic [PAGE_BITS-1:0]   fl_page_q;
   logic [3:0]             fl_lock_q;
   logic                   cpu_halt_q;
   logic                   irq_q;
   logic [15:0]            buf_data_q;

   // page buffer and its written-once mask
   logic [15:0]            buf_mem [NWORDS];
   logic [NWORDS-1:0]      loaded_q;
   logic [NWORDS-1:0]      loaded_d;

   // decoded strobes
   logic                   wr_ctrl, wr_store, ctrl_take, store_go;
   logic                   go_load, go_erase, go_write, go_lock;
   logic                   go_bclr, go_other, op_done, expire, buf_clr;
   logic [4:0]             cmd_v;
   logic [PAGE_BITS-1:0]   ptr_page;     // page field of pointer
   logic [WORD_BITS-1:0]   ptr_word;     // word field of pointer
   logic                   idle;

   assign hreadyout    = hreadyout_q;
   assign hresp        = hresp_q;
   assign hrdata       = hrdata_q;
   assign fl_op        = fl_op_q;
   assign fl_start     = fl_start_q;
   assign fl_page      = fl_page_q;
   assign fl_lock_bits = fl_lock_q;
   assign fl_buf_data  = buf_data_q;
   assign cpu_halt     = cpu_halt_q;
   assign section_block = busy_q;    // reads of section blocked while busy
   assign spm_irq      = irq_q;
   // byte address including bit 0 for program memory load
   assign load_addr    = ptr_q;

   // pointer fields: bit 0 selects a byte and is unused by commands
   assign ptr_page = ptr_q[15:WORD_BITS+1];
   assign ptr_word = ptr_q[WORD_BITS:1];

   assign idle     = (state_q == fsps_pkg::FSPS_IDLE);
   assign acc      = hsel & htrans[1] & hready;
   assign wr_ctrl  = wr_pend_q & (wr_ofs_q == `FSPS_OFS_CTRL);
   assign wr_store = wr_pend_q & (wr_ofs_q == `FSPS_OFS_STORE);
   // control writes are refused during an eeprom write or an operation
   assign ctrl_take = wr_ctrl & idle & ~eeprom_write_busy;
   // a store counts only inside the arm window of an enabled command
   assign store_go = wr_store & idle & pgm_en_q & (cnt_q != 3'd0)
                   & ~eeprom_write_busy;
   assign cmd_v    = {bclr_q, lock_q, wrt_q, ers_q, pgm_en_q};
   assign go_load  = store_go & (cmd_v == `FSPS_PAT_LOAD);
   assign go_erase = store_go & (cmd_v == `FSPS_PAT_ERASE);
   assign go_write = store_go & (cmd_v == `FSPS_PAT_WRITE);
   assign go_lock  = store_go & (cmd_v == `FSPS_PAT_LOCK);
   assign go_bclr  = store_go & (cmd_v == `FSPS_PAT_BCLR);
   assign go_other = store_go & ~(go_load | go_erase | go_write
                                  | go_lock | go_bclr);
   assign op_done  = ~idle & fl_done;
   // window ran out with no store: cancel the armed command
   assign expire   = idle & (cnt_q == 3'd1) & ~store_go;

   // read mux, evaluated in the address phase
   always_comb begin
      rd_val = 32'h0000_0000;               // unmapped reads give zero
      unique case (haddr[7:0])
         `FSPS_OFS_CTRL: begin
            rd_val[`FSPS_BIT_PGM_EN] = pgm_en_q;
            rd_val[`FSPS_BIT_ERASE]  = ers_q;
            rd_val[`FSPS_BIT_WRITE]  = wrt_q;
            rd_val[`FSPS_BIT_LOCK]   = lock_q;
            rd_val[`FSPS_BIT_BCLR]   = bclr_q;
            rd_val[`FSPS_BIT_BUSY]   = busy_q;
            rd_val[`FSPS_BIT_IEN]    = ien_q;
         end
         `FSPS_OFS_POINTER: rd_val[15:0] = ptr_q;
         `FSPS_OFS_DATA:    rd_val[15:0] = data_q;
         `FSPS_OFS_LOAD: begin
            // blocked section reads back a fixed byte while it is busy
            if (busy_q && (ptr_page < LIVE_LIM)) begin
               rd_val[7:0] = `FSPS_BLOCKED_BYTE;
            end else begin
               rd_val[7:0] = load_rdata;
            end
         end
         default: rd_val = 32'h0000_0000;
      endcase
   end

   // bus slave: zero wait states, so the data phase is always one cycle
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         wr_pend_q   <= 1'b0;
         wr_ofs_q    <= 8'h00;
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         hrdata_q    <= `FSPS_RST_RDATA;
      end else begin
         wr_pend_q   <= acc & hwrite;
         wr_ofs_q    <= haddr[7:0];
         hreadyout_q <= 1'b1;
         hresp_q     <= 1'b0;
         if (acc && !hwrite) begin
            hrdata_q <= rd_val;
         end
      end
   end

   // pointer and data pair; free to change while an operation runs
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         ptr_q  <= `FSPS_RST_PTR;
         data_q <= `FSPS_RST_DATA;
      end else begin
         if (wr_pend_q && wr_ofs_q == `FSPS_OFS_POINTER) begin
            ptr_q <= hwdata[15:0];
         end
         if (wr_pend_q && wr_ofs_q == `FSPS_OFS_DATA) begin
            data_q <= hwdata[15:0];
         end
      end
   end

   // arm window: loaded by an enabling control write, counts down
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 3'd0;
      end else if (ctrl_take && hwdata[`FSPS_BIT_PGM_EN]) begin
         cnt_q <= `FSPS_ARM_CYCLES;
      end else if (store_go) begin
         cnt_q <= 3'd0;
      end else if (cnt_q != 3'd0) begin
         cnt_q <= cnt_q - 3'd1;
      end
   end

   // command bits: a fresh control write wins over any clearing event
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pgm_en_q <= 1'b0;
         ers_q    <= 1'b0;
         wrt_q    <= 1'b0;
         lock_q   <= 1'b0;
         bclr_q   <= 1'b0;
         ien_q    <= 1'b0;
      end else if (ctrl_take) begin
         pgm_en_q <= hwdata[`FSPS_BIT_PGM_EN];
         ers_q    <= hwdata[`FSPS_BIT_ERASE];
         wrt_q    <= hwdata[`FSPS_BIT_WRITE];
         lock_q   <= hwdata[`FSPS_BIT_LOCK];
         bclr_q   <= hwdata[`FSPS_BIT_BCLR];
         ien_q    <= hwdata[`FSPS_BIT_IEN];
      end else if (op_done || go_load || go_bclr || go_other || expire) begin
         // completion or cancel: clearing enable tells software it is done
         pgm_en_q <= 1'b0;
         ers_q    <= 1'b0;
         wrt_q    <= 1'b0;
         lock_q   <= 1'b0;
         bclr_q   <= 1'b0;
      end
   end

   // section busy flag: set by erase or write, held until busy-clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= 1'b0;
      end else if (go_erase || go_write) begin
         busy_q <= 1'b1;
      end else if (go_bclr) begin
         busy_q <= 1'b0;
      end
   end

   // operation sequencer toward the flash array
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         state_q    <= fsps_pkg::FSPS_IDLE;
         fl_op_q    <= fsps_pkg::FSPS_OP_NONE;
         fl_start_q <= 1'b0;
         fl_page_q  <= '0;
         fl_lock_q  <= `FSPS_RST_LOCK;
         cpu_halt_q <= 1'b0;
      end else begin
         fl_start_q <= 1'b0;
         unique case (state_q)
            fsps_pkg::FSPS_IDLE: begin
               if (go_erase || go_write) begin
                  // page latched now; each op takes its own pointer value
                  state_q    <= fsps_pkg::FSPS_BUSY;
                  fl_start_q <= 1'b1;
                  fl_op_q    <= go_erase ? fsps_pkg::FSPS_OP_ERASE
                                         : fsps_pkg::FSPS_OP_WRITE;
                  fl_page_q  <= ptr_page;
                  // halting section stops the core; other lets it fetch
                  cpu_halt_q <= (ptr_page >= LIVE_LIM);
               end else if (go_lock) begin
                  // pointer ignored, no section blocked, core runs on
                  state_q    <= fsps_pkg::FSPS_BUSY;
                  fl_start_q <= 1'b1;
                  fl_op_q    <= fsps_pkg::FSPS_OP_LOCK;
                  fl_lock_q  <= data_q[`FSPS_LOCK_MSB:`FSPS_LOCK_LSB];
                  cpu_halt_q <= 1'b0;
               end
            end
            fsps_pkg::FSPS_BUSY: begin
               if (fl_done) begin
                  state_q    <= fsps_pkg::FSPS_IDLE;
                  fl_op_q    <= fsps_pkg::FSPS_OP_NONE;
                  cpu_halt_q <= 1'b0;
               end
            end
         endcase
      end
   end

   // buffer clear sources; a same-cycle load still sets its mask bit, but its data is dropped if the word was already loaded
   assign buf_clr = (op_done && fl_op_q == fsps_pkg::FSPS_OP_WRITE)
                  | go_bclr
                  | (eeprom_write_start & (|loaded_q));

   always_comb begin
      loaded_d = buf_clr ? '0 : loaded_q;
      if (go_load) begin
         loaded_d[ptr_word] = 1'b1;
      end
   end

   // written-once mask; clearing it empties the buffer
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         loaded_q <= '0;
      end else begin
         loaded_q <= loaded_d;
      end
   end

   // buffer storage, no reset: the mask decides what is valid
   always_ff @(posedge mclk) begin
      // a second load to a written word is dropped
      if (go_load && !loaded_q[ptr_word]) begin
         buf_mem[ptr_word] <= data_q;
      end
   end

   // flash side buffer read; unloaded words read as erased
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         buf_data_q <= `FSPS_ERASED_WORD;
      end else if (loaded_q[fl_buf_idx]) begin
         buf_data_q <= buf_mem[fl_buf_idx];
      end else begin
         buf_data_q <= `FSPS_ERASED_WORD;
      end
   end

   // level interrupt, high while enabled and enable bit reads clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= ien_q & ~pgm_en_q;
      end
   end

   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);

   sequence arm_s;
      ctrl_take && hwdata[`FSPS_BIT_PGM_EN];
   endsequence
   sequence no_store_s;
      (!store_go && !ctrl_take)[*4];
   endsequence
   property expire_p;
      arm_s ##1 no_store_s |=> !pgm_en_q;
   endproperty

   arm_expiry_a: assert property (expire_p)
      else $error("armed command did not expire after four cycles");
   page_latch_a: assert property ((go_erase || go_write)
      |=> fl_start_q && fl_page_q == $past(ptr_page))
      else $error("flash page not latched from pointer at start");
   halt_select_a: assert property (fl_start_q
      && fl_op_q != fsps_pkg::FSPS_OP_LOCK
      |-> cpu_halt_q == (fl_page_q >= LIVE_LIM))
      else $error("cpu halt does not match target section");
   busy_during_a: assert property (!idle
      && fl_op_q != fsps_pkg::FSPS_OP_LOCK |-> busy_q && section_block)
      else $error("section not busy during erase or write");
   lock_readable_a: assert property (go_lock
      |=> !cpu_halt_q [*2])
      else $error("core halted while programming lock bits");
   busy_hold_a: assert property (busy_q && !go_bclr |=> busy_q)
      else $error("section busy flag dropped without busy clear");
   eeprom_block_a: assert property (eeprom_write_busy
      |=> !fl_start_q)
      else $error("flash operation started during eeprom write");
   write_clear_a: assert property (op_done && !go_load
      && fl_op_q == fsps_pkg::FSPS_OP_WRITE |=> loaded_q == '0)
      else $error("page buffer not cleared after page write");
   eeprom_discard_a: assert property (eeprom_write_start
      && !go_load |=> loaded_q == '0)
      else $error("buffer kept after eeprom write");
   // irq follows the enable seen one cycle earlier, so a control
   // write landing right after completion does not trip this
   done_clear_a: assert property (op_done && !ctrl_take
      |=> !pgm_en_q ##1 (spm_irq == $past(ien_q)))
      else $error("completion did not clear enable or raise irq");

   irq_level_a: assert property ((ien_q && !pgm_en_q) [*2]
      |-> spm_irq)
      else $error("interrupt low while enable bit clear");

endmodule

/* File: fsps_regs.svh */
`ifndef FSPS_REGS_SVH
`define FSPS_REGS_SVH

// register byte offsets (low address byte)
`define FSPS_OFS_CTRL     8'h00
`define FSPS_OFS_POINTER  8'h04
`define FSPS_OFS_DATA     8'h08
`define FSPS_OFS_STORE    8'h0c
`define FSPS_OFS_LOAD     8'h10

// control/status field positions
`define FSPS_BIT_PGM_EN   0
`define FSPS_BIT_ERASE    1
`define FSPS_BIT_WRITE    2
`define FSPS_BIT_LOCK     3
`define FSPS_BIT_BCLR     4
`define FSPS_BIT_BUSY     6
`define FSPS_BIT_IEN      7

// command patterns over {bclr, lock, write, erase, pgm_en}
`define FSPS_PAT_LOAD     5'h01
`define FSPS_PAT_ERASE    5'h03
`define FSPS_PAT_WRITE    5'h05
`define FSPS_PAT_LOCK     5'h09
`define FSPS_PAT_BCLR     5'h11

// lock value position in the low data byte
`define FSPS_LOCK_MSB     5
`define FSPS_LOCK_LSB     2

// store must follow the control write within this many cycles
`define FSPS_ARM_CYCLES   3'd4

// reset values and fixed read-back values
`define FSPS_RST_PTR      16'h0000
`define FSPS_RST_DATA     16'h0000
`define FSPS_RST_LOCK     4'hf
`define FSPS_RST_RDATA    32'h0000_0000
`define FSPS_ERASED_WORD  16'hffff
`define FSPS_BLOCKED_BYTE 8'h00

`endif

/* File: fsps_pkg.sv */
package fsps_pkg;

   // operation handed to the flash array
   typedef enum logic [1:0] {
      FSPS_OP_NONE,
      FSPS_OP_ERASE,
      FSPS_OP_WRITE,
      FSPS_OP_LOCK
   } fsps_op_t;

   // sequencer states
   typedef enum logic {
      FSPS_IDLE,
      FSPS_BUSY
   } fsps_state_t;

endpackage

/* File: fsps_flash_model.sv */
`timescale 1ns/1ps
// behavioural flash array on the far side of the sequencer
module fsps_flash_model (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        fl_start,
   input  wire logic [7:0]  done_delay,
   input  wire logic [15:0] fl_buf_data,
   input  wire logic [15:0] load_addr,
   output logic             fl_done,
   output logic [5:0]       fl_buf_idx,
   output logic [7:0]       load_rdata
);
   logic [7:0]  cnt_q;     // cycles left in the operation
   logic        run_q;     // operation in flight
   logic [5:0]  idx_q;     // index asked for one cycle ago
   logic [15:0] seen [64]; // last word seen per buffer index

   // fixed latency per operation; the bench picks prompt or slow
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         run_q <= 1'b0;
         cnt_q <= 8'h00;
         fl_done <= 1'b0;
      end else begin
         fl_done <= 1'b0;
         if (fl_start) begin
            run_q <= 1'b1;
            cnt_q <= done_delay;
         end else if (run_q && cnt_q == 8'h00) begin
            fl_done <= 1'b1;
            run_q <= 1'b0;
         end else if (run_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end

   // endless buffer scan, so any word can be inspected later
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         fl_buf_idx <= 6'h00;
         idx_q <= 6'h00;
      end else begin
         fl_buf_idx <= fl_buf_idx + 6'h01;
         idx_q <= fl_buf_idx;
         seen[idx_q] <= fl_buf_data; // data lags index one cycle
      end
   end

   // byte pattern depends on every address bit, bit0 included
   assign load_rdata = load_addr[7:0] ^ load_addr[15:8];
endmodule

/* File: testbench.sv */
`timescale 1ns/1ps
`include "fsps_regs.svh"
module testbench;
   logic               mclk, arst_n, hwrite, hreadyout, hresp, hit;
   logic [1:0]         htrans;
   logic [31:0]        haddr, hwdata, hrdata, rd;
   logic               eeprom_write_busy, eeprom_write_start;
   fsps_pkg::fsps_op_t fl_op;
   logic               fl_start, fl_done, cpu_halt, section_block, spm_irq;
   logic [8:0]         fl_page;
   logic [3:0]         fl_lock_bits;
   logic [5:0]         fl_buf_idx;
   logic [15:0]        fl_buf_data, load_addr;
   logic [7:0]         load_rdata, dly;
   int                 err_total, compares;

   fsps_sequencer DUT (.mclk(mclk), .arst_n(arst_n), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .eeprom_write_busy(eeprom_write_busy),
      .eeprom_write_start(eeprom_write_start), .fl_op(fl_op),
      .fl_start(fl_start), .fl_page(fl_page), .fl_lock_bits(fl_lock_bits),
      .fl_done(fl_done), .fl_buf_idx(fl_buf_idx), .fl_buf_data(fl_buf_data),
      .load_addr(load_addr), .load_rdata(load_rdata), .cpu_halt(cpu_halt),
      .section_block(section_block), .spm_irq(spm_irq));

   fsps_flash_model flash (.mclk(mclk), .arst_n(arst_n),
      .fl_start(fl_start), .done_delay(dly), .fl_buf_data(fl_buf_data),
      .load_addr(load_addr), .fl_done(fl_done), .fl_buf_idx(fl_buf_idx),
      .load_rdata(load_rdata));

   // 100 MHz clock
   initial mclk = 1'b0;
   always #5 mclk = ~mclk;

   task automatic report_and_stop;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // one comparison, counted; case equality so unknowns fail
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   // single write; called right after an edge, held until hready
   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 1'b1;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
   endtask

   // single read; data taken at the data-phase edge
   task automatic bus_rd(input logic [7:0] a);
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= 1'b0;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   // control write, then store after g idle cycles (g=2 is last legal)
   task automatic arm(input logic [7:0] c, input int g);
      bus_wr(`FSPS_OFS_CTRL, {24'h0, c});
      repeat (g) @(posedge mclk);
      bus_wr(`FSPS_OFS_STORE, 32'h0);
   endtask

   // look for the start pulse over the three cycles after the store
   task automatic see_start;
      hit = 1'b0;
      repeat (3) begin
         #1;
         if (fl_start === 1'b1) hit = 1'b1;
         @(posedge mclk);
      end
   endtask

   // bounded wait for the array to finish; running out is a mismatch
   task automatic wait_idle;
      for (int i = 0; i < 300 && fl_op !== fsps_pkg::FSPS_OP_NONE; i++)
         @(posedge mclk);
      repeat (2) @(posedge mclk);
      chk(32'(fl_op), 32'(fsps_pkg::FSPS_OP_NONE));
   endtask

   // let the model sweep the whole buffer once
   task automatic scan;
      repeat (70) @(posedge mclk);
   endtask

   task automatic t_reset;
      chk({11'h0, hresp, fl_lock_bits, fl_buf_data}, 32'h000fffff);
      bus_rd(`FSPS_OFS_CTRL);
      chk(rd, 32'h0);
      bus_wr(8'h20, 32'hffffffff); // unmapped, dropped
      bus_rd(8'h20);
      chk(rd, 32'h0);
      bus_wr(`FSPS_OFS_POINTER, 32'h1235); // odd byte address
      bus_rd(`FSPS_OFS_LOAD);
      chk(rd, 32'h27);
      chk({16'h0, load_addr}, 32'h1235);
   endtask

   // erase in the halting section, pointer moved mid-operation
   task automatic t_erase;
      bus_wr(`FSPS_OFS_DATA, 32'h5555); // ignored by erase
      bus_wr(`FSPS_OFS_POINTER, 32'he10e); // page 450, stray word bits
      arm(8'h03, 0);
      see_start;
      chk({31'h0, hit}, 32'h1);
      chk(32'(fl_op), 32'(fsps_pkg::FSPS_OP_ERASE));
      chk(32'(fl_page), 32'd450);
      chk({31'h0, cpu_halt}, 32'h1);
      bus_wr(`FSPS_OFS_POINTER, 32'h0080);
      bus_wr(`FSPS_OFS_CTRL, 32'h11); // refused while busy
      bus_rd(`FSPS_OFS_LOAD);
      chk(rd, 32'h0);
      chk(32'(fl_page), 32'd450);
      wait_idle;
      chk({31'h0, cpu_halt}, 32'h0);
      bus_rd(`FSPS_OFS_CTRL);
      chk(rd, 32'h40);
      arm(8'h11, 0);
      bus_rd(`FSPS_OFS_CTRL);
      chk(rd, 32'h0);
   endtask

   // fill two words (one twice), write page 5, buffer must empty
   task automatic t_load_write;
      bus_wr(`FSPS_OFS_POINTER, 32'h0286);
      bus_wr(`FSPS_OFS_DATA, 32'hbeef);
      arm(8'h01, 0);
      bus_wr(`FSPS_OFS_DATA, 32'h1234); // second load, same word
      arm(8'h01, 0);
      bus_wr(`FSPS_OFS_POINTER, 32'h02fe); // last word of page
      bus_wr(`FSPS_OFS_DATA, 32'h0f0f);
      arm(8'h01, 0);
      scan;
      chk({16'h0, flash.seen[3]}, 32'hbeef);
      chk({16'h0, flash.seen[63]}, 32'h0f0f);
      chk({16'h0, flash.seen[4]}, 32'hffff);
      bus_wr(`FSPS_OFS_POINTER, 32'h0280);
      arm(8'h05, 0);
      see_start;
      chk({31'h0, hit}, 32'h1);
      chk(32'(fl_op), 32'(fsps_pkg::FSPS_OP_WRITE));
      chk(32'(fl_page), 32'd5);
      chk({30'h0, cpu_halt, section_block}, 32'h1);
      wait_idle;
      bus_rd(`FSPS_OFS_CTRL);
      chk(rd, 32'h40);
      scan;
      chk({16'h0, flash.seen[3]}, 32'hffff);
      arm(8'h11, 0);
      // the flag drops at the store edge; look one edge later
      @(posedge mclk);
      chk({31'h0, section_block}, 32'h0);
   endtask

   // lock bits 5:2 = 1010, spare bits one, pointer one
   task automatic t_lock;
      bus_wr(`FSPS_OFS_POINTER, 32'h0001);
      bus_wr(`FSPS_OFS_DATA, 32'h00eb);
      arm(8'h09, 0);
      see_start;
      chk({31'h0, hit}, 32'h1);
      chk({28'h0, fl_lock_bits}, 32'ha);
      chk({30'h0, cpu_halt, section_block}, 32'h0);
      wait_idle;
      bus_rd(`FSPS_OFS_CTRL);
      chk(rd, 32'h0);
   endtask

   // store on the last legal edge, then one edge too late
   task automatic t_expiry;
      dly <= 8'd2;
      for (int g = 2; g < 4; g++) begin
         arm(8'h09, g);
         see_start;
         chk({31'h0, hit}, 32'(g == 2));
         wait_idle;
         bus_rd(`FSPS_OFS_CTRL);
         chk(rd, 32'h0);
      end
   endtask

   // eeprom start drops the partial buffer; eeprom busy blocks commands
   task automatic t_eeprom;
      bus_wr(`FSPS_OFS_POINTER, 32'h0284);
      bus_wr(`FSPS_OFS_DATA, 32'h7777);
      arm(8'h01, 0);
      scan;
      chk({16'h0, flash.seen[2]}, 32'h7777);
      eeprom_write_start <= 1'b1;
      @(posedge mclk);
      eeprom_write_start <= 1'b0;
      scan;
      chk({16'h0, flash.seen[2]}, 32'hffff);
      eeprom_write_busy <= 1'b1;
      arm(8'h03, 0);
      see_start;
      chk({31'h0, hit}, 32'h0);
      bus_rd(`FSPS_OFS_CTRL);
      chk(rd, 32'h0);
      // software sees eeprom idle before any later arming
      eeprom_write_busy <= 1'b0;
   endtask

   // interrupt follows the enable bit and a cleared program enable
   task automatic t_irq;
      bus_wr(`FSPS_OFS_CTRL, 32'h80);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, spm_irq}, 32'h1);
      @(posedge mclk);
      bus_wr(`FSPS_OFS_CTRL, 32'h81);
      @(posedge mclk);
      #1 chk({31'h0, spm_irq}, 32'h0);
      repeat (6) @(posedge mclk);
      #1 chk({31'h0, spm_irq}, 32'h1);
      @(posedge mclk);
      bus_wr(`FSPS_OFS_CTRL, 32'h00);
      repeat (2) @(posedge mclk);
      #1 chk({31'h0, spm_irq}, 32'h0);
   endtask

   // main sequence
   initial begin
      arst_n = 1'b0;
      htrans = 2'b00;
      haddr = 32'h0;
      hwdata = 32'h0;
      hwrite = 1'b0;
      eeprom_write_busy = 1'b0;
      eeprom_write_start = 1'b0;
      dly = 8'd30;
      err_total = 0;
      compares = 0;
      repeat (4) @(posedge mclk);
      arst_n <= 1'b1;
      @(posedge mclk);
      t_reset;
      // interrupt enable stays clear while pages are programmed
      t_erase;
      t_load_write;
      t_lock;
      t_expiry;
      t_eeprom;
      t_irq;
      report_and_stop;
   end

   // watchdog: the whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge mclk);
      err_total++;
      report_and_stop;
   end
endmodule
